// [verilog/ucg_pkg.sv]
package ucg_pkg;
    // ---------------------------------------------------------------
    // Clock and divider
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int DIV_W = 12;
    localparam int DATA_W = 8;
    localparam int OVS_NORMAL = 16;
    localparam int OVS_DOUBLE = 8;
    localparam int OVS_SYNC = 2;
    localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
    // Partner clock period in core cycles; must stay above 4
    localparam int PAR_XCK_PERIOD = 8;
    localparam int PAR_XCK_HALF = PAR_XCK_PERIOD / 2;
    // ---------------------------------------------------------------
    // Frame format
    // ---------------------------------------------------------------
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } ucg_tx_st_t;
    typedef enum logic [1:0] {
        RX_IDLE, RX_DATA, RX_PAR, RX_STOP
    } ucg_rx_st_t;
endpackage

// [verilog/ucg_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface ucg_link_if;
    logic dev_txd;
    logic par_txd;
    logic dev_xck;
    logic dev_xck_oe;
    logic par_xck;
    logic par_xck_oe;
    logic xck;
    // Undriven clock line reads low, as if pulled down
    assign xck = dev_xck_oe ? dev_xck : (par_xck_oe ? par_xck : 1'b0);
    modport dev (
        output dev_txd, dev_xck, dev_xck_oe,
        input par_txd, xck
    );
    modport par (
        output par_txd, par_xck, par_xck_oe,
        input dev_txd, xck
    );
endinterface
`default_nettype wire

// [verilog/ucg_device.sv]
`timescale 1ns/1ns
`default_nettype none
//Function
// (RL1) Mode bit selects async or sync; four modes
// (RL2) Sync pin direction picks master or slave clock
// (RL3) Clock pin idle and ignored in async
// (RL4) Counter reloads at zero or low write
// (RL5) Tick at zero: core clock over divisor+1
// (RL6) Transmitter divides ticks by 16, 8, 2
// (RL7) Receiver phase machine of 16, 8, 2 states
// (RL8) Divisor is twelve bits, high and low
// (RL9) Double speed ignored in sync mode
// (RL10) Software keeps double speed clear in sync
// (RL11) Double speed halves receiver samples to 8
// (RL12) Slave clock synchronised then edge detected
// (RL13) Slave clock below quarter core clock
// (RL14) Sync pin drives in master, listens in slave
// (RL15) Sample on edge opposite data change
// (RL16) Polarity picks change and sample edges
// (RL17) One transmit buffer ahead of shifter
// (RL18) Two level receive buffer
// (RL19) Frame, overrun and parity errors flagged
// (RL20) Software clears power gate before use
// (RL21) Reset clears counter, synchroniser, detector
module ucg_device (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sync_mode_select,
    input wire logic double_speed_select,
    input wire logic xfer_clock_pin_direction,
    input wire logic clock_edge_polarity,
    input wire logic serial_power_gate,
    input wire logic [1:0] parity_mode,
    input wire logic [3:0] baud_divisor_high,
    input wire logic [7:0] baud_divisor_low,
    input wire logic baud_low_wr,
    input wire logic [7:0] tx_data,
    input wire logic tx_write,
    output logic tx_buffer_empty,
    input wire logic rx_read,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic frame_error,
    output logic parity_error,
    output logic data_overrun,
    ucg_link_if.dev link
);
    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    function automatic logic [3:0] last_phase(input logic sync,
                                              input logic dbl);
        if (sync) begin
            return 4'(ucg_pkg::OVS_SYNC - 1);
        end else if (dbl) begin
            return 4'(ucg_pkg::OVS_DOUBLE - 1);
        end
        return 4'(ucg_pkg::OVS_NORMAL - 1);
    endfunction

    logic async_m, master_m, slave_m, run;
    logic [3:0] last, mid;
    logic [11:0] baud_div;
    assign async_m = !sync_mode_select; // RL1
    assign master_m = sync_mode_select && xfer_clock_pin_direction; // RL2
    assign slave_m = sync_mode_select && !xfer_clock_pin_direction; // RL2
    assign run = !serial_power_gate;
    assign last = last_phase(sync_mode_select, double_speed_select); // RL9
    assign mid = last >> 1;
    assign baud_div = {baud_divisor_high, baud_divisor_low}; // RL8

    // ---------------------------------------------------------------
    // Clock generation
    // ---------------------------------------------------------------
    logic [11:0] cnt_q, cnt_d;
    logic tick_q, tick_d, xck_q, xck_d, oe_q, oe_d;
    logic xs1_q, xs2_q, xs3_q, rd1_q, rd2_q;
    logic rise_q, rise_d, fall_q, fall_d;
    logic [3:0] tdiv_q, tdiv_d, rph_q, rph_d;
    logic rrun_q, rrun_d, tx_evt, rx_evt;
    ucg_pkg::ucg_rx_st_t rx_st_q, rx_st_d;

    always_comb begin
        if (!run || baud_low_wr || cnt_q == 12'h000) begin
            cnt_d = baud_div; // RL4
        end else begin
            cnt_d = cnt_q - 12'h001;
        end
        tick_d = run && cnt_q == 12'h000; // RL5
        // Master clock toggles per tick: two ticks per bit
        xck_d = master_m ? (tick_q ? !xck_q : xck_q) : 1'b0; // RL6
        oe_d = master_m && run; // RL14
        if (master_m) begin
            rise_d = tick_q && !xck_q;
            fall_d = tick_q && xck_q;
        end else begin
            rise_d = slave_m && xs2_q && !xs3_q; // RL12
            fall_d = slave_m && !xs2_q && xs3_q; // RL12
        end
        tdiv_d = tdiv_q;
        if (tick_q) begin
            tdiv_d = (tdiv_q >= last) ? 4'h0 : tdiv_q + 4'h1; // RL6
        end
        rph_d = rph_q;
        rrun_d = rrun_q;
        if (!async_m || !run) begin
            rrun_d = 1'b0;
        end else if (!rrun_q) begin
            if (tick_q && !rd2_q && rx_st_q == ucg_pkg::RX_IDLE) begin
                rrun_d = 1'b1;
                rph_d = 4'h0;
            end
        end else if (tick_q) begin
            rph_d = (rph_q >= last) ? 4'h0 : rph_q + 4'h1; // RL7
            if (rx_evt && ((rx_st_q == ucg_pkg::RX_IDLE && rd2_q) ||
                           rx_st_q == ucg_pkg::RX_STOP)) begin
                rrun_d = 1'b0;
            end
        end
    end

    // Change and sample edges sit on opposite clock edges
    assign tx_evt = async_m ? (tick_q && tdiv_q >= last)
                  : (clock_edge_polarity ? fall_q : rise_q); // RL16
    // Sample mid-bit, phase counted in 16 or 8 ticks
    assign rx_evt = async_m ? (tick_q && rrun_q && rph_q == mid) // RL11
                  : (clock_edge_polarity ? rise_q : fall_q); // RL15

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= ucg_pkg::DIV_RESET; // RL21
            tick_q <= 1'b0;
            xck_q <= 1'b0;
            oe_q <= 1'b0;
            xs1_q <= 1'b0;
            xs2_q <= 1'b0;
            xs3_q <= 1'b0;
            rd1_q <= 1'b1;
            rd2_q <= 1'b1;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            tdiv_q <= 4'h0;
            rph_q <= 4'h0;
            rrun_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            xck_q <= xck_d;
            oe_q <= oe_d;
            xs1_q <= link.xck; // RL12
            xs2_q <= xs1_q;
            xs3_q <= xs2_q;
            rd1_q <= link.par_txd;
            rd2_q <= rd1_q;
            rise_q <= rise_d;
            fall_q <= fall_d;
            tdiv_q <= tdiv_d;
            rph_q <= rph_d;
            rrun_q <= rrun_d;
        end
    end

    // Pin is released whenever async mode is on
    assign link.dev_xck = xck_q; // RL3
    assign link.dev_xck_oe = oe_q; // RL3

    // ---------------------------------------------------------------
    // Transmitter
    // ---------------------------------------------------------------
    ucg_pkg::ucg_tx_st_t tx_st_q, tx_st_d;
    logic [7:0] tsh_q, tsh_d, tbuf_q, tbuf_d;
    logic [2:0] tcnt_q, tcnt_d;
    logic tpar_q, tpar_d, txd_q, txd_d, tbe_q, tbe_d;

    always_comb begin
        tx_st_d = tx_st_q;
        tsh_d = tsh_q;
        tcnt_d = tcnt_q;
        tpar_d = tpar_q;
        txd_d = txd_q;
        tbuf_d = tbuf_q;
        tbe_d = tbe_q;
        if (tx_write && tbe_q) begin
            tbuf_d = tx_data;
            tbe_d = 1'b0;
        end
        if (!run) begin
            tx_st_d = ucg_pkg::TX_IDLE;
            txd_d = 1'b1;
        end else if (tx_evt) begin
            case (tx_st_q)
                ucg_pkg::TX_IDLE, ucg_pkg::TX_STOP: begin
                    txd_d = 1'b1;
                    tx_st_d = ucg_pkg::TX_IDLE;
                    // Buffer feeds the shifter right after a stop bit
                    if (!tbe_q) begin
                        tsh_d = tbuf_q; // RL17
                        tbe_d = 1'b1;
                        txd_d = 1'b0;
                        tx_st_d = ucg_pkg::TX_START;
                    end
                end
                ucg_pkg::TX_START: begin
                    txd_d = tsh_q[0];
                    tpar_d = tsh_q[0];
                    tcnt_d = 3'h0;
                    tx_st_d = ucg_pkg::TX_DATA;
                end
                ucg_pkg::TX_DATA: begin
                    if (tcnt_q == ucg_pkg::LAST_BIT) begin
                        if (parity_mode[1]) begin
                            txd_d = tpar_q ^ parity_mode[0];
                            tx_st_d = ucg_pkg::TX_PAR;
                        end else begin
                            txd_d = 1'b1;
                            tx_st_d = ucg_pkg::TX_STOP;
                        end
                    end else begin
                        tsh_d = tsh_q >> 1;
                        txd_d = tsh_q[1];
                        tpar_d = tpar_q ^ tsh_q[1];
                        tcnt_d = tcnt_q + 3'h1;
                    end
                end
                ucg_pkg::TX_PAR: begin
                    txd_d = 1'b1;
                    tx_st_d = ucg_pkg::TX_STOP;
                end
                default: tx_st_d = ucg_pkg::TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q <= ucg_pkg::TX_IDLE;
            tsh_q <= 8'h00;
            tcnt_q <= 3'h0;
            tpar_q <= 1'b0;
            txd_q <= 1'b1;
            tbuf_q <= 8'h00;
            tbe_q <= 1'b1;
        end else begin
            tx_st_q <= tx_st_d;
            tsh_q <= tsh_d;
            tcnt_q <= tcnt_d;
            tpar_q <= tpar_d;
            txd_q <= txd_d;
            tbuf_q <= tbuf_d;
            tbe_q <= tbe_d;
        end
    end

    assign link.dev_txd = txd_q;
    assign tx_buffer_empty = tbe_q;

    // ---------------------------------------------------------------
    // Receiver with two entry buffer {parity err, frame err, data}
    // ---------------------------------------------------------------
    logic [7:0] rsh_q, rsh_d;
    logic [2:0] rcnt_q, rcnt_d;
    logic rpar_q, rpar_d, rpe_q, rpe_d, ovr_q, ovr_d;
    logic [9:0] ent_q [2];
    logic [9:0] ent_d [2];
    logic [1:0] v_q, v_d;
    logic push;
    logic [9:0] frame;

    always_comb begin
        rx_st_d = rx_st_q;
        rsh_d = rsh_q;
        rcnt_d = rcnt_q;
        rpar_d = rpar_q;
        rpe_d = rpe_q;
        push = 1'b0;
        frame = {rpe_q, !rd2_q, rsh_q};
        if (!run) begin
            rx_st_d = ucg_pkg::RX_IDLE;
        end else if (rx_evt) begin
            case (rx_st_q)
                ucg_pkg::RX_IDLE: begin
                    if (!rd2_q) begin
                        rx_st_d = ucg_pkg::RX_DATA;
                        rcnt_d = 3'h0;
                        rpar_d = 1'b0;
                        rpe_d = 1'b0;
                    end
                end
                ucg_pkg::RX_DATA: begin
                    rsh_d = {rd2_q, rsh_q[7:1]};
                    rpar_d = rpar_q ^ rd2_q;
                    rcnt_d = rcnt_q + 3'h1;
                    if (rcnt_q == ucg_pkg::LAST_BIT) begin
                        rx_st_d = parity_mode[1] ? ucg_pkg::RX_PAR
                                : ucg_pkg::RX_STOP;
                    end
                end
                ucg_pkg::RX_PAR: begin
                    rpe_d = rpar_q ^ rd2_q ^ parity_mode[0]; // RL19
                    rx_st_d = ucg_pkg::RX_STOP;
                end
                ucg_pkg::RX_STOP: begin
                    push = 1'b1; // RL19
                    rx_st_d = ucg_pkg::RX_IDLE;
                end
                default: rx_st_d = ucg_pkg::RX_IDLE;
            endcase
        end
        // Pop first, so a read frees room for a frame ending now
        ent_d[0] = ent_q[0];
        ent_d[1] = ent_q[1];
        v_d = v_q;
        if (rx_read && v_q[0]) begin
            ent_d[0] = ent_q[1];
            v_d = {1'b0, v_q[1]};
        end
        ovr_d = ovr_q && !rx_read;
        if (push) begin
            if (!v_d[0]) begin
                ent_d[0] = frame; // RL18
                v_d[0] = 1'b1;
            end else if (!v_d[1]) begin
                ent_d[1] = frame; // RL18
                v_d[1] = 1'b1;
            end else begin
                ovr_d = 1'b1; // RL19
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_q <= ucg_pkg::RX_IDLE;
            rsh_q <= 8'h00;
            rcnt_q <= 3'h0;
            rpar_q <= 1'b0;
            rpe_q <= 1'b0;
            ovr_q <= 1'b0;
            ent_q[0] <= 10'h000;
            ent_q[1] <= 10'h000;
            v_q <= 2'h0;
        end else begin
            rx_st_q <= rx_st_d;
            rsh_q <= rsh_d;
            rcnt_q <= rcnt_d;
            rpar_q <= rpar_d;
            rpe_q <= rpe_d;
            ovr_q <= ovr_d;
            ent_q[0] <= ent_d[0];
            ent_q[1] <= ent_d[1];
            v_q <= v_d;
        end
    end

    assign rx_data = ent_q[0][7:0];
    assign frame_error = ent_q[0][8];
    assign parity_error = ent_q[0][9];
    assign rx_valid = v_q[0];
    assign data_overrun = ovr_q;
endmodule
`default_nettype wire

// [verilog/ucg_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module ucg_partner #(
    parameter int XCK_HALF = ucg_pkg::PAR_XCK_HALF
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic is_master,
    input wire logic clock_edge_polarity,
    input wire logic [1:0] parity_mode,
    input wire logic [7:0] tx_data,
    input wire logic tx_write,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_parity_error,
    output logic rx_frame_error,
    ucg_link_if.par link
);
    // ---------------------------------------------------------------
    // Clock: own divider as master, synchronised pin as slave
    // ---------------------------------------------------------------
    // Half period of at least 4 keeps the clock under a quarter
    logic [7:0] hc_q, hc_d;
    logic xck_q, xck_d, oe_q, xs1_q, xs2_q, xs3_q, rd1_q, rd2_q;
    logic rise_q, rise_d, fall_q, fall_d, tx_evt, rx_evt;

    always_comb begin
        hc_d = hc_q + 8'h01;
        xck_d = is_master ? xck_q : 1'b0;
        if (!is_master || hc_q >= 8'(XCK_HALF - 1)) begin
            hc_d = 8'h00;
        end
        if (is_master && hc_q >= 8'(XCK_HALF - 1)) begin
            xck_d = !xck_q; // RL13
        end
        rise_d = is_master ? (xck_d && !xck_q) : (xs2_q && !xs3_q);
        fall_d = is_master ? (!xck_d && xck_q) : (!xs2_q && xs3_q);
    end

    assign tx_evt = clock_edge_polarity ? fall_q : rise_q; // RL16
    assign rx_evt = clock_edge_polarity ? rise_q : fall_q; // RL15

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hc_q <= 8'h00;
            xck_q <= 1'b0;
            oe_q <= 1'b0;
            xs1_q <= 1'b0;
            xs2_q <= 1'b0;
            xs3_q <= 1'b0;
            rd1_q <= 1'b1;
            rd2_q <= 1'b1;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            hc_q <= hc_d;
            xck_q <= xck_d;
            oe_q <= is_master;
            xs1_q <= link.xck;
            xs2_q <= xs1_q;
            xs3_q <= xs2_q;
            rd1_q <= link.dev_txd;
            rd2_q <= rd1_q;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign link.par_xck = xck_q;
    assign link.par_xck_oe = oe_q;

    // ---------------------------------------------------------------
    // Serial engines, one frame buffer each way
    // ---------------------------------------------------------------
    ucg_pkg::ucg_tx_st_t tx_st_q, tx_st_d;
    ucg_pkg::ucg_rx_st_t rx_st_q, rx_st_d;
    logic [7:0] tsh_q, tsh_d, rsh_q, rsh_d, rdat_q, rdat_d;
    logic [2:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
    logic tpar_q, tpar_d, txd_q, txd_d, trdy_q, trdy_d;
    logic rpar_q, rpar_d, rpe_q, rpe_d, rv_q, rv_d, rfe_q, rfe_d;
    logic [7:0] tb_q, tb_d;

    always_comb begin
        tx_st_d = tx_st_q;
        tsh_d = tsh_q;
        tcnt_d = tcnt_q;
        tpar_d = tpar_q;
        txd_d = txd_q;
        tb_d = tb_q;
        trdy_d = trdy_q;
        if (tx_write && trdy_q) begin
            tb_d = tx_data;
            trdy_d = 1'b0;
        end
        if (tx_evt) begin
            case (tx_st_q)
                ucg_pkg::TX_IDLE, ucg_pkg::TX_STOP: begin
                    txd_d = 1'b1;
                    tx_st_d = ucg_pkg::TX_IDLE;
                    if (!trdy_q) begin
                        tsh_d = tb_q;
                        trdy_d = 1'b1;
                        txd_d = 1'b0;
                        tx_st_d = ucg_pkg::TX_START;
                    end
                end
                ucg_pkg::TX_START: begin
                    txd_d = tsh_q[0];
                    tpar_d = tsh_q[0];
                    tcnt_d = 3'h0;
                    tx_st_d = ucg_pkg::TX_DATA;
                end
                ucg_pkg::TX_DATA: begin
                    if (tcnt_q == ucg_pkg::LAST_BIT) begin
                        txd_d = parity_mode[1]
                              ? tpar_q ^ parity_mode[0] : 1'b1;
                        tx_st_d = parity_mode[1] ? ucg_pkg::TX_PAR
                                : ucg_pkg::TX_STOP;
                    end else begin
                        tsh_d = tsh_q >> 1;
                        txd_d = tsh_q[1];
                        tpar_d = tpar_q ^ tsh_q[1];
                        tcnt_d = tcnt_q + 3'h1;
                    end
                end
                ucg_pkg::TX_PAR: begin
                    txd_d = 1'b1;
                    tx_st_d = ucg_pkg::TX_STOP;
                end
                default: tx_st_d = ucg_pkg::TX_IDLE;
            endcase
        end
        rx_st_d = rx_st_q;
        rsh_d = rsh_q;
        rcnt_d = rcnt_q;
        rpar_d = rpar_q;
        rpe_d = rpe_q;
        rdat_d = rdat_q;
        rfe_d = rfe_q;
        rv_d = 1'b0;
        if (rx_evt) begin
            case (rx_st_q)
                ucg_pkg::RX_IDLE: begin
                    if (!rd2_q) begin
                        rx_st_d = ucg_pkg::RX_DATA;
                        rcnt_d = 3'h0;
                        rpar_d = 1'b0;
                        rpe_d = 1'b0;
                    end
                end
                ucg_pkg::RX_DATA: begin
                    rsh_d = {rd2_q, rsh_q[7:1]};
                    rpar_d = rpar_q ^ rd2_q;
                    rcnt_d = rcnt_q + 3'h1;
                    if (rcnt_q == ucg_pkg::LAST_BIT) begin
                        rx_st_d = parity_mode[1] ? ucg_pkg::RX_PAR
                                : ucg_pkg::RX_STOP;
                    end
                end
                ucg_pkg::RX_PAR: begin
                    rpe_d = rpar_q ^ rd2_q ^ parity_mode[0];
                    rx_st_d = ucg_pkg::RX_STOP;
                end
                ucg_pkg::RX_STOP: begin
                    rdat_d = rsh_q;
                    rfe_d = !rd2_q;
                    rv_d = 1'b1;
                    rx_st_d = ucg_pkg::RX_IDLE;
                end
                default: rx_st_d = ucg_pkg::RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q <= ucg_pkg::TX_IDLE;
            rx_st_q <= ucg_pkg::RX_IDLE;
            tsh_q <= 8'h00;
            rsh_q <= 8'h00;
            rdat_q <= 8'h00;
            tb_q <= 8'h00;
            tcnt_q <= 3'h0;
            rcnt_q <= 3'h0;
            tpar_q <= 1'b0;
            rpar_q <= 1'b0;
            txd_q <= 1'b1;
            trdy_q <= 1'b1;
            rpe_q <= 1'b0;
            rfe_q <= 1'b0;
            rv_q <= 1'b0;
        end else begin
            tx_st_q <= tx_st_d;
            rx_st_q <= rx_st_d;
            tsh_q <= tsh_d;
            rsh_q <= rsh_d;
            rdat_q <= rdat_d;
            tb_q <= tb_d;
            tcnt_q <= tcnt_d;
            rcnt_q <= rcnt_d;
            tpar_q <= tpar_d;
            rpar_q <= rpar_d;
            txd_q <= txd_d;
            trdy_q <= trdy_d;
            rpe_q <= rpe_d;
            rfe_q <= rfe_d;
            rv_q <= rv_d;
        end
    end

    assign link.par_txd = txd_q;
    assign tx_ready = trdy_q;
    assign rx_data = rdat_q;
    assign rx_valid = rv_q;
    assign rx_parity_error = rpe_q;
    assign rx_frame_error = rfe_q;
endmodule
`default_nettype wire

// [test/ucg_link_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module ucg_link_asserts (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic dev_txd,
    input wire logic par_txd,
    input wire logic dev_xck_oe,
    input wire logic par_xck_oe,
    input wire logic xck
);
    // ---------------------
    // Link timing
    // ---------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_rst; $rose(rst_b) |-> dev_txd && par_txd && !xck; endproperty
    a_rst: assert property (p_rst) else $error("busy at reset");
    property p_one; !(dev_xck_oe && par_xck_oe); endproperty
    a_one: assert property (p_one) else $error("two drivers");
    property p_txw; $changed(dev_txd) |=> $stable(dev_txd); endproperty
    a_txw: assert property (p_txw) else $error("short bit");
    property p_ptw; $changed(par_txd) |=> $stable(par_txd) [*2]; endproperty
    a_ptw: assert property (p_ptw) else $error("short bit");
    // Master is only run with divisor 1 or more
    property p_mrt;
        dev_xck_oe && $changed(xck) |=> $stable(xck);
    endproperty
    a_mrt: assert property (p_mrt) else $error("fast clock");
    property p_mch;
        dev_xck_oe && $changed(dev_txd) |-> $past(xck, 1) != $past(xck, 2);
    endproperty
    a_mch: assert property (p_mch) else $error("change off edge");
    property p_sch;
        par_xck_oe && $changed(dev_txd) |-> ($past(xck, 3) ^ $past(xck, 4))
            | ($past(xck, 4) ^ $past(xck, 5)) | ($past(xck, 5) ^ $past(xck, 6));
    endproperty
    a_sch: assert property (p_sch) else $error("slave latency");
    property p_srt;
        par_xck_oe && $changed(xck) |=> (!par_xck_oe || $stable(xck)) [*2];
    endproperty
    a_srt: assert property (p_srt) else $error("slave clock fast");
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    failures++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb;
    // ---------------------
    // Wiring
    // ---------------------
    // Config bits: sync, double, master, polarity, parity, divisor
    logic [17:0] cfg = 18'h00000;
    logic core_clk = 1'b0, rst_b = 1'b0, low_wr = 1'b0;
    logic d_wr = 1'b0, d_rd = 1'b0, p_wr = 1'b0;
    logic [7:0] p_txd = 8'h6e, d_rx, p_rx, p_got;
    logic d_val, d_fe, d_pe, d_ovr, p_rdy, p_val, p_pe, d_tbe;
    int failures = 0, checks_done = 0, cyc = 0, n;
    ucg_link_if link ();
    ucg_device ucg_device_inst (.core_clk(core_clk), .rst_b(rst_b),
        .sync_mode_select(cfg[17]), .double_speed_select(cfg[16]),
        .xfer_clock_pin_direction(cfg[15]), .clock_edge_polarity(cfg[14]),
        .serial_power_gate(1'b0), .parity_mode(cfg[13:12]),
        .baud_divisor_high(cfg[11:8]), .baud_divisor_low(cfg[7:0]),
        .baud_low_wr(low_wr), .tx_data(8'h9b), .tx_write(d_wr),
        .tx_buffer_empty(d_tbe), .rx_read(d_rd), .rx_data(d_rx),
        .rx_valid(d_val),
        .frame_error(d_fe), .parity_error(d_pe), .data_overrun(d_ovr),
        .link(link.dev));
    ucg_partner ucg_partner_inst (.core_clk(core_clk), .rst_b(rst_b),
        .is_master(cfg[17] & ~cfg[15]), .clock_edge_polarity(cfg[14]),
        .parity_mode(cfg[13:12]), .tx_data(p_txd), .tx_write(p_wr),
        .tx_ready(p_rdy), .rx_data(p_rx), .rx_valid(p_val),
        .rx_parity_error(p_pe), .rx_frame_error(), .link(link.par));
    ucg_link_asserts ucg_link_asserts_inst (.core_clk(core_clk),
        .rst_b(rst_b), .dev_txd(link.dev_txd), .par_txd(link.par_txd),
        .dev_xck_oe(link.dev_xck_oe), .par_xck_oe(link.par_xck_oe),
        .xck(link.xck));
    always #20 core_clk = ~core_clk;
    // Partner valid is a pulse, so hold its data
    always @(posedge core_clk) begin
        cyc++;
        if (!rst_b)
            p_got <= 8'hxx;
        else if (p_val === 1'b1)
            p_got <= p_rx;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic rd();
        d_rd = 1'b1;
        tick();
        d_rd = 1'b0;
    endtask
    task automatic run(input logic [17:0] c, input int exp);
        rst_b = 1'b0;
        cfg = c;
        repeat (3) tick();
        rst_b = 1'b1;
        low_wr = 1'b1;
        tick();
        low_wr = 1'b0;
        d_wr = 1'b1;
        p_wr = c[17];
        tick();
        d_wr = 1'b0;
        p_wr = 1'b0;
        `CHK("buffer taken", 1'b0, d_tbe)
        for (n = 0; n < 999 && link.dev_txd !== 1'b0; n++)
            tick();
        `CHK("buffer freed", 1'b1, d_tbe)
        `CHK("clock drive", c[17] & c[15], link.dev_xck_oe)
        for (n = 0; n < 999 && link.dev_txd === 1'b0; n++)
            tick();
        `CHK("start bit cycles", exp, n)
        if (c[17]) begin
            for (n = 0; n < 999 && (d_val !== 1'b1 || p_got !== 8'h9b); n++)
                tick();
            `CHK("device rx", p_txd, d_rx)
            `CHK("partner rx", 8'h9b, p_got)
            `CHK("rx errors", 3'h0, {d_fe, d_pe, p_pe})
            rd();
        end
    endtask
    initial begin
        run(18'h00000, 16);
        run(18'h10002, 24);
        run(18'h02004, 80);
        run(18'h2a001, 4);
        run(18'h2f001, 4);
        run(18'h26001, 8);
        run(18'h23001, 8);
        // Three frames unread: third must be lost
        for (int i = 1; i < 4; i++) begin
            for (n = 0; n < 999 && p_rdy !== 1'b1; n++)
                tick();
            p_txd = 8'(i);
            p_wr = 1'b1;
            tick();
            p_wr = 1'b0;
            tick();
        end
        for (n = 0; n < 999 && d_ovr !== 1'b1; n++)
            tick();
        `CHK("overrun set", 1'b1, d_ovr)
        `CHK("oldest entry", 8'h01, d_rx)
        rd();
        `CHK("second entry", 8'h02, d_rx)
        `CHK("overrun cleared", 1'b0, d_ovr)
        complete_run();
    end
endmodule
`default_nettype wire
